/* dv/kpm_host_model.sv */
`timescale 1ns/10ps
module kpm_host_model #(
  parameter int BIT_CYC = 4160
)(
  // Clock
  input  wire logic clk,
  // Line from device
  input  wire logic host_txd,
  // Lines into device
  output logic      host_rxd,
  output logic      alpha_rxd
);
  logic [7:0] rx_q[$];
  longint     st_q[$];
  int         frm_err;
  longint     cyc;

  initial begin
    host_rxd  = 1'b1;
    alpha_rxd = 1'b1;
    frm_err   = 0;
    cyc       = 0;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // ****************************************
  // Receive from device, centre sampling
  // ****************************************
  initial begin : rx_proc
    logic [7:0] b;
    forever begin
      @(negedge host_txd);
      st_q.push_back(cyc);
      repeat (BIT_CYC / 2) @(posedge clk);
      if (host_txd !== 1'b0) frm_err++;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        b[i] = host_txd;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (host_txd !== 1'b1) frm_err++;
      rx_q.push_back(b);
    end
  end

  // ****************************************
  // Send one 8N1 character, LSB first
  // ****************************************
  task automatic send_byte(input bit to_alpha, input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (to_alpha) alpha_rxd = fr[i];
      else host_rxd = fr[i];
      repeat (BIT_CYC) @(posedge clk);
      #1;
    end
  endtask : send_byte
endmodule : kpm_host_model

/* dv/tb_top.sv */
`timescale 1ns/10ps
`include "kpm_params.svh"
module tb_top;
  import kpm_pkg::*;
  localparam int SMP     = 50;
  localparam int BIT_CYC = 16 * `KPM_OVS_DIV;
  localparam int NK      = `KPM_NKEYS;

  logic          clk;
  logic          nrst;
  logic [3:0]    kbd_num;
  logic [NK-1:0] key_b1;
  logic [NK-1:0] key_b2;
  logic [63:0]   ctrl_val;
  logic          host_rxd;
  logic          host_txd;
  logic          alpha_rxd;
  logic [95:0]   disp_chars;
  int            miscompares;
  int            cmp_count;
  logic [7:0]    exp_q[$];
  int            key;
  int            nt;
  int            cidx;
  logic [7:0]    cval;
  logic [7:0]    achr;

  kpm_merger #(.SMP_PERIOD_CYC(SMP)) u_kpm_merger (
    .clk(clk), .nrst(nrst), .kbd_num(kbd_num), .key_b1(key_b1), .key_b2(key_b2),
    .ctrl_val(ctrl_val), .host_rxd(host_rxd), .host_txd(host_txd), .alpha_rxd(alpha_rxd),
    .disp_chars(disp_chars)
  );
  kpm_host_model #(.BIT_CYC(BIT_CYC)) u_kpm_host_model (
    .clk(clk), .host_txd(host_txd), .host_rxd(host_rxd), .alpha_rxd(alpha_rxd)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ****************************************
  // Compare and verdict
  // ****************************************
  task automatic chk_val(input string nm, input logic [95:0] e, input logic [95:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_rng(input string nm, input logic [63:0] lo, input logic [63:0] hi, input logic [63:0] g);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      miscompares++;
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic push3(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    exp_q.push_back(b0);
    exp_q.push_back(b1);
    exp_q.push_back(b2);
  endtask : push3

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (20 * 10 * BIT_CYC) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h120ed8c4));
    nrst        = 1'b0;
    miscompares = 0;
    cmp_count   = 0;
    kbd_num     = 4'($urandom_range(15));
    key_b1      = '1;
    key_b2      = '0;
    ctrl_val    = '0;
    key         = $urandom_range(NK - 1);
    nt          = $urandom_range(20, 3);
    cidx        = $urandom_range(7);
    cval        = 8'($urandom_range(255, 1));
    achr        = 8'($urandom_range(126, 33));
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    @(posedge clk);
    #1;
    chk_val("display after reset", `KPM_PWR_MSG, disp_chars);
    chk_val("idle host line", 96'h1, 96'(host_txd));
    fork
      begin
        // Host clears the display and writes two characters
        u_kpm_host_model.send_byte(1'b0, `KPM_CHAR_CR);
        u_kpm_host_model.send_byte(1'b0, 8'h4F);
        u_kpm_host_model.send_byte(1'b0, 8'h4B);
        repeat (4) @(posedge clk);
        chk_val("display text", 96'h4F4B20202020202020202020, disp_chars);
      end
      begin
        // Timed key travel, then release, control move and alpha key during the packet
        key_b1[key] = 1'b0;
        repeat (400 * nt + 200) @(posedge clk);
        #1;
        key_b2[key] = 1'b1;
        push3(8'h90 | 8'(kbd_num), 8'(key), 8'hFF - 8'(nt));
        for (int i = 0; i < 100 && u_kpm_host_model.st_q.size() == 0; i++) @(posedge clk);
        #1;
        key_b2[key]          = 1'b0;
        ctrl_val[8*cidx +: 8] = cval;
        @(posedge clk);
        #1;
        key_b1[key] = 1'b1;
        push3(8'h80 | 8'(kbd_num), 8'(key), 8'h00);
        push3(8'hA0 | 8'(cidx), cval, 8'h00);
        push3(8'hC0, achr, 8'h00);
        u_kpm_host_model.send_byte(1'b1, achr);
      end
    join
    for (int i = 0; i < 12 * 10 * BIT_CYC && u_kpm_host_model.rx_q.size() < 12; i++) @(posedge clk);
    chk_val("stop bit errors", 96'h0, 96'(u_kpm_host_model.frm_err));
    chk_val("byte count", 96'd12, 96'(u_kpm_host_model.rx_q.size()));
    for (int i = 0; i < 12; i++) begin
      if (i == 2) chk_rng("press velocity", 64'(exp_q[2] - 8'h01), 64'(exp_q[2]), 64'(u_kpm_host_model.rx_q[2]));
      else chk_val("host byte", 96'(exp_q[i]), 96'(u_kpm_host_model.rx_q[i]));
    end
    for (int p = 0; p < 4; p++) begin
      for (int j = 1; j < 3; j++) begin
        chk_rng("byte spacing", 10 * BIT_CYC - 2, 10 * BIT_CYC + 8,
                64'(u_kpm_host_model.st_q[3*p+j] - u_kpm_host_model.st_q[3*p+j-1]));
      end
    end
    print_verdict();
  end
endmodule : tb_top

/* hdl/kpm_merger.sv */
`timescale 1ns/10ps
`include "kpm_params.svh"
module kpm_merger
  import kpm_pkg::*;
#(
  parameter int SMP_PERIOD_CYC = `KPM_SMP_PERIOD_CYC
)(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Keyboard identity
  input  wire logic [3:0]                  kbd_num,
  // Key contacts: at rest on first busbar, fully down on second
  input  wire logic [`KPM_NKEYS-1:0]       key_b1,
  input  wire logic [`KPM_NKEYS-1:0]       key_b2,
  // Digitised faders, switches, pedals
  input  wire logic [8*`KPM_NCTRL-1:0]     ctrl_val,
  // Host link
  input  wire logic                        host_rxd,
  output logic                             host_txd,
  // Alpha keyboard line
  input  wire logic                        alpha_rxd,
  // Display, character 0 in the top byte
  output logic [8*`KPM_DISP_LEN-1:0]       disp_chars
);
  localparam int OVS_DIV = `KPM_OVS_DIV;
  localparam int VEL_CYC = `KPM_VEL_TICK_CYC;

  // ****************************************
  // Rate dividers
  // ****************************************
  logic [8:0]  ovs_cnt_ff, nxt_ovs_cnt;
  logic [8:0]  vel_cnt_ff, nxt_vel_cnt;
  logic [15:0] smp_cnt_ff, nxt_smp_cnt;
  logic        ovs_tick, vel_tick, smp_tick;

  assign ovs_tick = (ovs_cnt_ff == 9'(OVS_DIV - 1));
  assign vel_tick = (vel_cnt_ff == 9'(VEL_CYC - 1));
  assign smp_tick = (smp_cnt_ff == 16'(SMP_PERIOD_CYC - 1));

  always_comb begin
    nxt_ovs_cnt = ovs_tick ? 9'h000 : ovs_cnt_ff + 9'h001;
    nxt_vel_cnt = vel_tick ? 9'h000 : vel_cnt_ff + 9'h001;
    nxt_smp_cnt = smp_tick ? 16'h0000 : smp_cnt_ff + 16'h0001;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovs_cnt_ff <= 9'h000;
      vel_cnt_ff <= 9'h000;
      smp_cnt_ff <= 16'h0000;
    end else begin
      ovs_cnt_ff <= nxt_ovs_cnt;
      vel_cnt_ff <= nxt_vel_cnt;
      smp_cnt_ff <= nxt_smp_cnt;
    end
  end

  // ****************************************
  // Serial ports
  // ****************************************
  logic       tx_valid, tx_ready, host_rx_valid, alpha_rx_valid;
  logic [7:0] tx_data, host_rx_data, alpha_rx_data;

  kpm_uart u_host (
    .clk(clk), .nrst(nrst), .tick(ovs_tick),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .txd(host_txd),
    .rxd(host_rxd), .rx_valid(host_rx_valid), .rx_data(host_rx_data)
  );

  kpm_uart u_alpha (
    .clk(clk), .nrst(nrst), .tick(ovs_tick),
    .tx_valid(1'b0), .tx_data(8'h00), .tx_ready(), .txd(),
    .rxd(alpha_rxd), .rx_valid(alpha_rx_valid), .rx_data(alpha_rx_data)
  );

  // ****************************************
  // Key events and velocity timing
  // ****************************************
  logic [`KPM_NKEYS-1:0]   key_pend, key_dir, key_clr;
  logic [8*`KPM_NKEYS-1:0] key_vel;

  for (genvar gi = 0; gi < `KPM_NKEYS; gi++) begin : g_key
    logic       b2_ff,   nxt_b2;
    logic [7:0] cnt_ff,  nxt_cnt;
    logic       pend_ff, nxt_pend;
    logic       dir_ff,  nxt_dir;
    logic [7:0] vel_ff,  nxt_vel;
    always_comb begin
      nxt_b2   = key_b2[gi];
      nxt_cnt  = cnt_ff;
      nxt_pend = pend_ff;
      nxt_dir  = dir_ff;
      nxt_vel  = vel_ff;
      if (key_b1[gi]) begin
        nxt_cnt = 8'h00;
      end else if (!key_b2[gi] && vel_tick && cnt_ff != `KPM_VEL_MAX) begin
        nxt_cnt = cnt_ff + 8'h01;
      end
      if (key_clr[gi]) begin
        nxt_pend = 1'b0;
      end
      if (key_b2[gi] != b2_ff) begin
        nxt_pend = 1'b1;
        nxt_dir  = key_b2[gi];
        nxt_vel  = key_b2[gi] ? `KPM_VEL_MAX - cnt_ff : 8'h00;
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        b2_ff   <= 1'b0;
        cnt_ff  <= 8'h00;
        pend_ff <= 1'b0;
        dir_ff  <= 1'b0;
        vel_ff  <= 8'h00;
      end else begin
        b2_ff   <= nxt_b2;
        cnt_ff  <= nxt_cnt;
        pend_ff <= nxt_pend;
        dir_ff  <= nxt_dir;
        vel_ff  <= nxt_vel;
      end
    end
    assign key_pend[gi]       = pend_ff;
    assign key_dir[gi]        = dir_ff;
    assign key_vel[gi*8 +: 8] = vel_ff;
  end

  // ****************************************
  // Control change detection
  // ****************************************
  logic [`KPM_NCTRL-1:0]   ctrl_pend, ctrl_clr;
  logic [8*`KPM_NCTRL-1:0] ctrl_last;

  for (genvar gc = 0; gc < `KPM_NCTRL; gc++) begin : g_ctrl
    logic [7:0] prev_ff, nxt_prev;
    logic       pend_ff, nxt_pend;
    always_comb begin
      nxt_prev = prev_ff;
      nxt_pend = pend_ff;
      if (ctrl_clr[gc]) begin
        nxt_pend = 1'b0;
      end
      if (smp_tick && ctrl_val[gc*8 +: 8] != prev_ff) begin
        nxt_prev = ctrl_val[gc*8 +: 8];
        nxt_pend = 1'b1;
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        prev_ff <= 8'h00;
        pend_ff <= 1'b0;
      end else begin
        prev_ff <= nxt_prev;
        pend_ff <= nxt_pend;
      end
    end
    assign ctrl_pend[gc]        = pend_ff;
    assign ctrl_last[gc*8 +: 8] = prev_ff;
  end

  // ****************************************
  // Alpha character queue
  // ****************************************
  logic [7:0] aq_mem_ff [`KPM_AQ_DEPTH];
  logic [3:0] aq_wr_ff, nxt_aq_wr, aq_rd_ff, nxt_aq_rd;
  logic       aq_empty, aq_full, aq_pop;

  assign aq_empty = (aq_wr_ff == aq_rd_ff);
  assign aq_full  = (aq_wr_ff[2:0] == aq_rd_ff[2:0]) && !aq_empty;

  always_comb begin
    nxt_aq_wr = (alpha_rx_valid && !aq_full) ? aq_wr_ff + 4'h1 : aq_wr_ff;
    nxt_aq_rd = aq_pop ? aq_rd_ff + 4'h1 : aq_rd_ff;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aq_wr_ff <= 4'h0;
      aq_rd_ff <= 4'h0;
    end else begin
      aq_wr_ff <= nxt_aq_wr;
      aq_rd_ff <= nxt_aq_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (alpha_rx_valid && !aq_full) begin
      aq_mem_ff[aq_wr_ff[2:0]] <= alpha_rx_data;
    end
  end

  // ****************************************
  // Packet sequencer
  // ****************************************
  kpm_seq_t    seq_ff, nxt_seq;
  logic [23:0] pkt_ff, nxt_pkt;
  logic [1:0]  idx_ff, nxt_idx;
  logic        key_any, ctrl_any, tx_fire;
  logic [6:0]  key_sel;
  logic [2:0]  ctrl_sel;

  assign key_any  = |key_pend;
  assign ctrl_any = |ctrl_pend;
  assign tx_valid = (seq_ff == SQ_SEND);
  assign tx_data  = pkt_ff[23 - 8*idx_ff -: 8];
  assign tx_fire  = tx_valid && tx_ready;
  assign aq_pop   = (seq_ff == SQ_IDLE) && !key_any && !ctrl_any && !aq_empty;

  always_comb begin
    key_sel  = 7'h00;
    ctrl_sel = 3'h0;
    for (int i = `KPM_NKEYS - 1; i >= 0; i--) begin
      if (key_pend[i]) begin
        key_sel = 7'(i);
      end
    end
    for (int j = `KPM_NCTRL - 1; j >= 0; j--) begin
      if (ctrl_pend[j]) begin
        ctrl_sel = 3'(j);
      end
    end
  end

  always_comb begin
    nxt_seq  = seq_ff;
    nxt_pkt  = pkt_ff;
    nxt_idx  = idx_ff;
    key_clr  = '0;
    ctrl_clr = '0;
    unique case (seq_ff)
      SQ_IDLE: begin
        nxt_idx = 2'h0;
        if (key_any) begin
          nxt_pkt = {`KPM_TAG_KEY, key_dir[key_sel], kbd_num, 1'b0, key_sel,
                     key_vel[key_sel*8 +: 8]};
          key_clr[key_sel] = 1'b1;
          nxt_seq = SQ_SEND;
        end else if (ctrl_any) begin
          nxt_pkt = {`KPM_TAG_CTRL, 2'h0, ctrl_sel, ctrl_last[ctrl_sel*8 +: 8], 8'h00};
          ctrl_clr[ctrl_sel] = 1'b1;
          nxt_seq = SQ_SEND;
        end else if (!aq_empty) begin
          nxt_pkt = {`KPM_TAG_ALPHA, 5'h00, aq_mem_ff[aq_rd_ff[2:0]], 8'h00};
          nxt_seq = SQ_SEND;
        end
      end
      SQ_SEND: begin
        if (tx_fire) begin
          nxt_idx = idx_ff + 2'h1;
          if (idx_ff == 2'h2) begin
            nxt_seq = SQ_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_ff <= SQ_IDLE;
      pkt_ff <= 24'h000000;
      idx_ff <= 2'h0;
    end else begin
      seq_ff <= nxt_seq;
      pkt_ff <= nxt_pkt;
      idx_ff <= nxt_idx;
    end
  end

  // ****************************************
  // Message display
  // ****************************************
  logic [8*`KPM_DISP_LEN-1:0] disp_ff, nxt_disp;
  logic [3:0]                 pos_ff, nxt_pos;
  logic                       seen_ff, nxt_seen;

  assign disp_chars = disp_ff;

  always_comb begin
    nxt_disp = disp_ff;
    nxt_pos  = pos_ff;
    nxt_seen = seen_ff || host_rx_valid;
    if (host_rx_valid) begin
      if (host_rx_data == `KPM_CHAR_CR) begin
        nxt_disp = `KPM_DISP_BLANK;
        nxt_pos  = 4'h0;
      end else if (pos_ff < 4'(`KPM_DISP_LEN)) begin
        nxt_disp[(`KPM_DISP_LEN - 1 - pos_ff)*8 +: 8] = host_rx_data;
        nxt_pos = pos_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      disp_ff <= `KPM_PWR_MSG;
      pos_ff  <= 4'h0;
      seen_ff <= 1'b0;
    end else begin
      disp_ff <= nxt_disp;
      pos_ff  <= nxt_pos;
      seen_ff <= nxt_seen;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_BAUD_DIV: assert property (ovs_tick |-> $past(ovs_cnt_ff) == 9'(OVS_DIV - 2))
    else $error("oversample divider period wrong");
  AST_KEY_PKT: assert property (seq_ff == SQ_IDLE && key_any |=> seq_ff == SQ_SEND && pkt_ff[23:21] == `KPM_TAG_KEY)
    else $error("key event not framed as key packet");
  AST_KEY_SENT: assert property ($rose(key_b2[0]) |=> g_key[0].pend_ff)
    else $error("key press not flagged for sending");
  AST_VELOCITY: assert property ($rose(key_b2[0]) |=> g_key[0].vel_ff == `KPM_VEL_MAX - $past(g_key[0].cnt_ff))
    else $error("velocity does not follow travel time");
  AST_CTRL_CHANGE: assert property (smp_tick && ctrl_val[7:0] != g_ctrl[0].prev_ff |=> g_ctrl[0].pend_ff)
    else $error("control change not flagged");
  AST_CTRL_STEADY: assert property (smp_tick && ctrl_val[7:0] == g_ctrl[0].prev_ff && !g_ctrl[0].pend_ff |=> !g_ctrl[0].pend_ff)
    else $error("unchanged control flagged");
  AST_ALPHA_LAST: assert property (aq_pop |-> !key_any && !ctrl_any)
    else $error("alpha sent while music data waits");
  AST_CONTIG: assert property (seq_ff == SQ_SEND && !(tx_fire && idx_ff == 2'h2) |=> seq_ff == SQ_SEND && $stable(pkt_ff))
    else $error("packet broken before its last byte");
  AST_PWR_MSG: assert property (!seen_ff |-> disp_ff == `KPM_PWR_MSG)
    else $error("power-on message missing");
  AST_HOST_CR: assert property (host_rx_valid && host_rx_data == `KPM_CHAR_CR |=> pos_ff == 4'h0 && disp_ff == `KPM_DISP_BLANK)
    else $error("carriage return did not clear display");

  CVR_KEY_PKT:   cover property (seq_ff == SQ_IDLE && key_any ##1 seq_ff == SQ_SEND);
  CVR_CTRL_PKT:  cover property (seq_ff == SQ_IDLE && !key_any && ctrl_any);
  CVR_ALPHA_PKT: cover property (aq_pop);
  CVR_HOST_CHAR: cover property (host_rx_valid && host_rx_data != `KPM_CHAR_CR);
endmodule : kpm_merger

/* hdl/kpm_params.svh */
// Summary of operation
// - Host link and alpha keyboard line both run asynchronous serial at 9600 baud.
// - Send data on music key down/up, alpha key, fader, switch or pedal change.
// - Each keystroke becomes a three-byte packet: keyboard, key, direction, velocity.
// - Velocity comes from timing key contact travel from first to second busbar.
// - After reset the 12-character display shows a local power-on message.
// - Characters received from the host are placed on the display.
// - Controls are sampled as eight-bit values; send only when a value changes.
// - Alpha characters are tagged, queued and sent only when no music data waits.
`ifndef KPM_PARAMS_SVH
`define KPM_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define KPM_CLK_MHZ          40
`define KPM_BAUD             9600
`define KPM_OVS              16
`define KPM_OVS_DIV          ((`KPM_CLK_MHZ * 1000000) / (`KPM_BAUD * `KPM_OVS))
`define KPM_VEL_TICK_US      10
`define KPM_VEL_TICK_CYC     (`KPM_VEL_TICK_US * `KPM_CLK_MHZ)
`define KPM_SMP_PERIOD_US    1000
`define KPM_SMP_PERIOD_CYC   (`KPM_SMP_PERIOD_US * `KPM_CLK_MHZ)

// ****************************************
// Sizes
// ****************************************
`define KPM_NKEYS            73
`define KPM_NCTRL            8
`define KPM_DISP_LEN         12
`define KPM_AQ_DEPTH         8

// ****************************************
// Packet layout and characters
// ****************************************
`define KPM_TAG_KEY          3'h4
`define KPM_TAG_CTRL         3'h5
`define KPM_TAG_ALPHA        3'h6
`define KPM_VEL_MAX          8'hFF
`define KPM_CHAR_CR          8'h0D
`define KPM_DISP_BLANK       96'h202020202020202020202020
`define KPM_PWR_MSG          96'h504F574552204F4E20202020
`define KPM_TX_IDLE_SH       10'h3FF

`endif

/* hdl/kpm_pkg.sv */
package kpm_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} kpm_rx_t;
  typedef enum logic       {SQ_IDLE, SQ_SEND} kpm_seq_t;
endpackage : kpm_pkg

/* hdl/kpm_uart.sv */
`timescale 1ns/10ps
`include "kpm_params.svh"
module kpm_uart
  import kpm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Oversample enable
  input  wire logic       tick,
  // Transmit side
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            txd,
  // Receive side
  input  wire logic       rxd,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic          tx_busy_ff, nxt_tx_busy;
  logic [9:0]    tx_sh_ff,   nxt_tx_sh;
  logic [3:0]    tx_bit_ff,  nxt_tx_bit;
  logic [3:0]    tx_ph_ff,   nxt_tx_ph;
  kpm_rx_t       rx_st_ff,   nxt_rx_st;
  logic [3:0]    rx_ph_ff,   nxt_rx_ph;
  logic [2:0]    rx_bit_ff,  nxt_rx_bit;
  logic [7:0]    rx_sh_ff,   nxt_rx_sh;
  logic [7:0]    rx_data_ff, nxt_rx_data;
  logic          rx_vld_ff,  nxt_rx_vld;

  // Loads only on an oversample tick so every bit, start included, is 16 ticks long;
  // the next byte may load on the tick that ends the stop bit, keeping bytes back to back
  assign tx_ready = tick && (!tx_busy_ff || (tx_ph_ff == 4'hF && tx_bit_ff == 4'h9));
  assign txd      = tx_sh_ff[0];
  assign rx_valid = rx_vld_ff;
  assign rx_data  = rx_data_ff;

  // ****************************************
  // Transmitter: start, 8 data LSB first, stop
  // ****************************************
  always_comb begin
    nxt_tx_busy = tx_busy_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_bit  = tx_bit_ff;
    nxt_tx_ph   = tx_ph_ff;
    if (tx_ready && tx_valid) begin
      nxt_tx_busy = 1'b1;
      nxt_tx_sh   = {1'b1, tx_data, 1'b0};
      nxt_tx_bit  = 4'h0;
      nxt_tx_ph   = 4'h0;
    end else if (tx_busy_ff && tick) begin
      nxt_tx_ph = tx_ph_ff + 4'h1;
      if (tx_ph_ff == 4'hF) begin
        nxt_tx_sh  = {1'b1, tx_sh_ff[9:1]};
        nxt_tx_bit = tx_bit_ff + 4'h1;
        if (tx_bit_ff == 4'h9) begin
          nxt_tx_busy = 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Receiver: mid-bit sampling
  // ****************************************
  always_comb begin
    nxt_rx_st   = rx_st_ff;
    nxt_rx_ph   = rx_ph_ff;
    nxt_rx_bit  = rx_bit_ff;
    nxt_rx_sh   = rx_sh_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_vld  = 1'b0;
    unique case (rx_st_ff)
      RX_IDLE: begin
        nxt_rx_ph = 4'h0;
        if (!rxd) begin
          nxt_rx_st = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          nxt_rx_ph = rx_ph_ff + 4'h1;
          if (rx_ph_ff == 4'h7) begin
            nxt_rx_ph  = 4'h0;
            nxt_rx_bit = 3'h0;
            nxt_rx_st  = rxd ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          nxt_rx_ph = rx_ph_ff + 4'h1;
          if (rx_ph_ff == 4'hF) begin
            nxt_rx_sh  = {rxd, rx_sh_ff[7:1]};
            nxt_rx_bit = rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'h7) begin
              nxt_rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          nxt_rx_ph = rx_ph_ff + 4'h1;
          if (rx_ph_ff == 4'hF) begin
            nxt_rx_st = RX_IDLE;
            if (rxd) begin
              nxt_rx_data = rx_sh_ff;
              nxt_rx_vld  = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_busy_ff <= 1'b0;
      tx_sh_ff   <= `KPM_TX_IDLE_SH;
      tx_bit_ff  <= 4'h0;
      tx_ph_ff   <= 4'h0;
      rx_st_ff   <= RX_IDLE;
      rx_ph_ff   <= 4'h0;
      rx_bit_ff  <= 3'h0;
      rx_sh_ff   <= 8'h00;
      rx_data_ff <= 8'h00;
      rx_vld_ff  <= 1'b0;
    end else begin
      tx_busy_ff <= nxt_tx_busy;
      tx_sh_ff   <= nxt_tx_sh;
      tx_bit_ff  <= nxt_tx_bit;
      tx_ph_ff   <= nxt_tx_ph;
      rx_st_ff   <= nxt_rx_st;
      rx_ph_ff   <= nxt_rx_ph;
      rx_bit_ff  <= nxt_rx_bit;
      rx_sh_ff   <= nxt_rx_sh;
      rx_data_ff <= nxt_rx_data;
      rx_vld_ff  <= nxt_rx_vld;
    end
  end
endmodule : kpm_uart
